// ===== pkg/pressure_fifo_pkg.sv
package pressure_fifo_pkg;

   localparam int SAMPLE_W = 24;
   localparam int STORE_DEPTH = 32;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam int SUM_W = 29;
   localparam int QUEUE_DEPTH = 8;
   localparam int TEMP_W = 16;

   localparam logic [7:0] ADDR_PRESS_XL = 8'h28;
   localparam logic [7:0] ADDR_PRESS_L = 8'h29;
   localparam logic [7:0] ADDR_PRESS_H = 8'h2A;
   localparam logic [7:0] ADDR_TEMP_H = 8'h2C;
   localparam logic [7:0] ADDR_FIFO_CTRL = 8'h2E;
   localparam logic [7:0] ADDR_FIFO_STATUS = 8'h2F;
   localparam logic [7:0] ADDR_THRESH_L = 8'h30;
   localparam logic [7:0] ADDR_THRESH_H = 8'h31;
   localparam logic [7:0] ADDR_OFFSET_L = 8'h39;
   localparam logic [7:0] ADDR_STEP = 8'h01;

   localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
   localparam logic [7:0] THRESH_RESET = 8'h00;
   localparam logic [7:0] OFFSET_L_RESET = 8'h38;
   localparam logic [7:0] READ_IDLE = 8'h00;

   localparam int MODE_HI = 7;
   localparam int MODE_LO = 5;
   localparam int WTM_HI = 4;
   localparam int WTM_LO = 0;
   localparam int TEMP_HI = 15;
   localparam int TEMP_LO = 8;

   localparam logic [2:0] MODE_BYPASS = 3'h0;
   localparam logic [2:0] MODE_FIFO = 3'h1;
   localparam logic [2:0] MODE_STREAM = 3'h2;
   localparam logic [2:0] MODE_STREAM_TO_FIFO = 3'h3;
   localparam logic [2:0] MODE_BYPASS_TO_STREAM = 3'h4;
   localparam logic [2:0] MODE_MEAN = 3'h6;
   localparam logic [2:0] MODE_BYPASS_TO_FIFO = 3'h7;

   // Cycles for the store's registered read to reflect a pointer move
   localparam logic [1:0] SETTLE_CYCLES = 2'h2;

   typedef enum logic [1:0] {BH_BYPASS, BH_FIFO, BH_STREAM, BH_MEAN} behaviour_t;

endpackage

// ===== src/sample_store_mem.sv
`timescale 1ns/1ps
module sample_store_mem #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] cell_ff [DEPTH];
   logic [WIDTH-1:0] rd_data_ff;

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         cell_ff[wr_addr] <= wr_data;
      end
   end

   // Old contents are returned when reading the address being written
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_ff <= '0;
      end else begin
         rd_data_ff <= cell_ff[rd_addr];
      end
   end

   assign rd_data = rd_data_ff;
endmodule

// ===== src/sample_queue.sv
`timescale 1ns/1ps
module sample_queue #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [WIDTH-1:0] slot_ff [DEPTH];
   logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic ready_ff, nxt_ready;
   logic push, pop;

   assign push = in_valid && ready_ff;
   assign pop = out_valid && out_ready;
   assign out_valid = cnt_ff != '0;
   assign out_data = slot_ff[rd_ff];
   assign in_ready = ready_ff;

   always_comb begin
      nxt_wr = push ? AW'(wr_ff + 1'h1) : wr_ff;
      nxt_rd = pop ? AW'(rd_ff + 1'h1) : rd_ff;
      nxt_cnt = CW'(cnt_ff + CW'(push) - CW'(pop));
      // Ready is registered so the source sees a flop; it is taken from the next count, so all DEPTH slots still fill
      nxt_ready = nxt_cnt != CW'(DEPTH);
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         slot_ff[wr_ff] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
         ready_ff <= 1'h0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
         ready_ff <= nxt_ready;
      end
   end
endmodule

// ===== src/pressure_sample_fifo_control.sv
`timescale 1ns/1ps
// What this block does
// (R1) Mode from control bits 7:5, reset zero
// (R2) Watermark level in control bits 4:0
// (R3) Bypass keeps store empty, result direct
// (R4) FIFO mode stops storing when full
// (R5) Stream mode drops oldest when full
// (R6) Code 011: stream, then FIFO after trigger
// (R7) Code 100: bypass, then stream after trigger
// (R8) Code 111: bypass, then FIFO after trigger
// (R9) Host never programs reserved code 101
// (R10) Code 110 outputs hardware running average
// (R11) Watermark code selects 2..32 sample window
// (R12) Host uses only listed window codes
// (R13) Average mode hides entries, reads average
// (R14) Status bit 7: level at/above watermark
// (R15) Status bit 6: store full
// (R16) Status bit 5: store empty
// (R17) Status bits 4:0 hold fill level
// (R18) Temperature high byte readable at 2Ch
// (R19) Sixteen-bit threshold at 30h/31h, reset zero
// (R20) Offset low byte at 39h, reset 38h
// (R21) Store holds thirty-two 24-bit entries
// (R22) Reading pops oldest entry into result
// (R23) Burst reads wrap 2Ah back to 28h; code wraps only in FIFO or stream behaviour, not bypass or average
// (R24) Trigger is an internal event input
// (R25) Mode applies per sample; bypass discards
module pressure_sample_fifo_control (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sample_valid,
   input wire logic [pressure_fifo_pkg::SAMPLE_W-1:0] sample_data,
   output logic sample_ready,
   input wire logic [pressure_fifo_pkg::TEMP_W-1:0] temperature_sample_bits,
   input wire logic trigger_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic [7:0] reg_next_addr,
   output logic [15:0] pressure_threshold_bits,
   output logic [7:0] pressure_offset_bits
);
   import pressure_fifo_pkg::*;

   logic [7:0] ctrl_ff, nxt_ctrl;
   logic [15:0] thresh_ff, nxt_thresh;
   logic [7:0] offset_ff, nxt_offset;
   logic [7:0] temp_high_ff;
   logic [7:0] rdata_ff, nxt_rdata;
   logic rvalid_ff, nxt_rvalid;
   logic [7:0] next_addr_ff, nxt_next_addr;
   logic switched_ff, nxt_switched, trig_prev_ff;

   logic [2:0] mode_ff, nxt_mode;
   behaviour_t last_bh_ff, nxt_last_bh;
   logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
   logic [CNT_W-1:0] count_ff, nxt_count;
   logic signed [SUM_W-1:0] sum_ff, nxt_sum;
   logic loaded_ff, nxt_loaded;
   logic [SAMPLE_W-1:0] result_ff, nxt_result;
   logic [1:0] settle_ff, nxt_settle;

   logic [4:0] wtm;
   logic [2:0] ctrl_mode;
   logic settled, accessible, pop_req, take;
   behaviour_t cur_bh, take_bh;
   logic q_valid, q_ready;
   logic [SAMPLE_W-1:0] q_data, mem_rdata, mem_wdata;
   logic mem_we;
   logic [PTR_W-1:0] mem_waddr;
   logic [CNT_W-1:0] window;
   logic [7:0] status;
   logic [PTR_W-1:0] b_wr, b_rd;
   logic [CNT_W-1:0] b_cnt;
   logic signed [SUM_W-1:0] b_sum, shifted;

   function automatic behaviour_t behaviour_of(input logic [2:0] m, input logic sw);
      case (m)
         MODE_FIFO: behaviour_of = BH_FIFO;
         MODE_STREAM: behaviour_of = BH_STREAM;
         MODE_STREAM_TO_FIFO: behaviour_of = sw ? BH_FIFO : BH_STREAM;      // R6
         MODE_BYPASS_TO_STREAM: behaviour_of = sw ? BH_STREAM : BH_BYPASS;  // R7
         MODE_BYPASS_TO_FIFO: behaviour_of = sw ? BH_FIFO : BH_BYPASS;      // R8
         MODE_MEAN: behaviour_of = BH_MEAN;                                 // R10
         // Reserved 101 is treated as bypass so a stray write cannot corrupt the store
         default: behaviour_of = BH_BYPASS;
      endcase
   endfunction

   function automatic logic [2:0] window_shift(input logic [4:0] w);
      case (w)
         5'h01: window_shift = 3'h1;
         5'h03: window_shift = 3'h2;
         5'h07: window_shift = 3'h3;
         5'h0F: window_shift = 3'h4;
         5'h1F: window_shift = 3'h5;
         default: window_shift = 3'h0;
      endcase
   endfunction

   function automatic logic signed [SUM_W-1:0] widen(input logic [SAMPLE_W-1:0] d);
      widen = signed'({{(SUM_W - SAMPLE_W){d[SAMPLE_W-1]}}, d});
   endfunction

   sample_queue #(
      .WIDTH(SAMPLE_W),
      .DEPTH(QUEUE_DEPTH)
   ) u_in_queue (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .in_valid(sample_valid),
      .in_data(sample_data),
      .in_ready(sample_ready),
      .out_valid(q_valid),
      .out_data(q_data),
      .out_ready(q_ready)
   );

   sample_store_mem #(
      .WIDTH(SAMPLE_W),
      .DEPTH(STORE_DEPTH),  // R21
      .AW(PTR_W)
   ) u_store (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(rd_ptr_ff),
      .rd_data(mem_rdata)
   );

   assign wtm = ctrl_ff[WTM_HI:WTM_LO];            // R2
   assign ctrl_mode = ctrl_ff[MODE_HI:MODE_LO];    // R1
   assign window = CNT_W'({1'h0, wtm} + 1'h1);     // R11
   assign settled = settle_ff == SETTLE_CYCLES;
   assign cur_bh = behaviour_of(mode_ff, switched_ff);
   assign accessible = (cur_bh == BH_FIFO) || (cur_bh == BH_STREAM);  // R13
   assign pop_req = reg_rd && (reg_addr == ADDR_PRESS_H) && accessible && loaded_ff;  // R22
   // Intake waits until the registered store read is current; the queue absorbs the stall
   assign q_ready = settled && !pop_req;
   assign take = q_valid && q_ready;
   assign take_bh = behaviour_of(ctrl_mode, switched_ff);  // R25
   assign status = {count_ff >= CNT_W'(wtm), count_ff == CNT_W'(STORE_DEPTH),  // R14 R15
                    count_ff == '0, count_ff[PTR_W-1:0]};                     // R16 R17

   // Store, mode and result
   always_comb begin
      nxt_mode = mode_ff;
      nxt_last_bh = last_bh_ff;
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count = count_ff;
      nxt_sum = sum_ff;
      nxt_loaded = loaded_ff;
      nxt_result = result_ff;
      mem_we = 1'h0;
      mem_waddr = wr_ptr_ff;
      mem_wdata = q_data;
      b_wr = wr_ptr_ff;
      b_rd = rd_ptr_ff;
      b_cnt = count_ff;
      b_sum = sum_ff;
      shifted = sum_ff;
      if (take) begin
         nxt_mode = ctrl_mode;  // R1 R25
         nxt_last_bh = take_bh;
         // Averaging restarts clean so the sum never carries entries it did not add
         if (take_bh == BH_BYPASS || (take_bh == BH_MEAN && last_bh_ff != BH_MEAN)) begin  // R3 R25
            b_wr = '0;
            b_rd = '0;
            b_cnt = '0;
            b_sum = '0;
            nxt_loaded = 1'h0;
         end
         nxt_wr_ptr = b_wr;
         nxt_rd_ptr = b_rd;
         nxt_count = b_cnt;
         nxt_sum = b_sum;
         mem_waddr = b_wr;
         case (take_bh)
            BH_BYPASS: begin
               nxt_result = q_data;  // R3
            end
            BH_FIFO: begin
               if (b_cnt != CNT_W'(STORE_DEPTH)) begin  // R4
                  mem_we = 1'h1;
                  nxt_wr_ptr = PTR_W'(b_wr + 1'h1);
                  nxt_count = CNT_W'(b_cnt + 1'h1);
               end
            end
            BH_STREAM: begin
               mem_we = 1'h1;
               nxt_wr_ptr = PTR_W'(b_wr + 1'h1);
               if (b_cnt == CNT_W'(STORE_DEPTH)) begin  // R5
                  nxt_rd_ptr = PTR_W'(b_rd + 1'h1);
                  nxt_loaded = 1'h0;
               end else begin
                  nxt_count = CNT_W'(b_cnt + 1'h1);
               end
            end
            BH_MEAN: begin
               mem_we = 1'h1;
               nxt_wr_ptr = PTR_W'(b_wr + 1'h1);
               if (b_cnt >= window) begin  // R10 R11
                  nxt_rd_ptr = PTR_W'(b_rd + 1'h1);
                  nxt_sum = SUM_W'(b_sum + widen(q_data) - widen(mem_rdata));
               end else begin
                  nxt_count = CNT_W'(b_cnt + 1'h1);
                  nxt_sum = SUM_W'(b_sum + widen(q_data));
               end
               shifted = nxt_sum >>> window_shift(wtm);
               nxt_result = shifted[SAMPLE_W-1:0];  // R13
            end
            default: ;
         endcase
      end else if (pop_req) begin
         nxt_rd_ptr = PTR_W'(rd_ptr_ff + 1'h1);  // R22
         nxt_count = CNT_W'(count_ff - 1'h1);
         nxt_loaded = 1'h0;
      end else if (!loaded_ff && count_ff != '0 && settled && accessible) begin
         nxt_result = mem_rdata;  // R22
         nxt_loaded = 1'h1;
      end
      if (nxt_wr_ptr != wr_ptr_ff || nxt_rd_ptr != rd_ptr_ff) begin
         nxt_settle = '0;
      end else if (!settled) begin
         nxt_settle = 2'(settle_ff + 1'h1);
      end else begin
         nxt_settle = settle_ff;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff <= MODE_BYPASS;
         last_bh_ff <= BH_BYPASS;
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
         sum_ff <= '0;
         loaded_ff <= 1'h0;
         result_ff <= '0;
         settle_ff <= '0;
      end else begin
         mode_ff <= nxt_mode;
         last_bh_ff <= nxt_last_bh;
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
         sum_ff <= nxt_sum;
         loaded_ff <= nxt_loaded;
         result_ff <= nxt_result;
         settle_ff <= nxt_settle;
      end
   end

   // Register access
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_thresh = thresh_ff;
      nxt_offset = offset_ff;
      nxt_rdata = rdata_ff;
      nxt_rvalid = 1'h0;
      nxt_next_addr = next_addr_ff;
      nxt_switched = switched_ff;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_FIFO_CTRL: begin
               nxt_ctrl = reg_wdata;  // R1 R2
               nxt_switched = 1'h0;
            end
            ADDR_THRESH_L: nxt_thresh[7:0] = reg_wdata;  // R19
            ADDR_THRESH_H: nxt_thresh[15:8] = reg_wdata;  // R19
            ADDR_OFFSET_L: nxt_offset = reg_wdata;  // R20
            default: ;
         endcase
      end
      // A trigger release in the same cycle as a mode write still counts
      if (trig_prev_ff && !trigger_in) begin
         nxt_switched = 1'h1;  // R24
      end
      if (reg_rd) begin
         nxt_rvalid = 1'h1;
         case (reg_addr)
            ADDR_PRESS_XL: nxt_rdata = result_ff[7:0];
            ADDR_PRESS_L: nxt_rdata = result_ff[15:8];
            ADDR_PRESS_H: nxt_rdata = result_ff[23:16];
            ADDR_TEMP_H: nxt_rdata = temp_high_ff;  // R18
            ADDR_FIFO_CTRL: nxt_rdata = ctrl_ff;
            ADDR_FIFO_STATUS: nxt_rdata = status;  // R17
            ADDR_THRESH_L: nxt_rdata = thresh_ff[7:0];
            ADDR_THRESH_H: nxt_rdata = thresh_ff[15:8];
            ADDR_OFFSET_L: nxt_rdata = offset_ff;
            default: nxt_rdata = READ_IDLE;
         endcase
         if (reg_addr == ADDR_PRESS_H && accessible) begin
            nxt_next_addr = ADDR_PRESS_XL;  // R23
         end else begin
            nxt_next_addr = 8'(reg_addr + ADDR_STEP);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= FIFO_CTRL_RESET;
         thresh_ff <= {THRESH_RESET, THRESH_RESET};
         offset_ff <= OFFSET_L_RESET;
         temp_high_ff <= READ_IDLE;
         rdata_ff <= READ_IDLE;
         rvalid_ff <= 1'h0;
         next_addr_ff <= ADDR_PRESS_XL;
         switched_ff <= 1'h0;
         trig_prev_ff <= 1'h0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         thresh_ff <= nxt_thresh;
         offset_ff <= nxt_offset;
         temp_high_ff <= temperature_sample_bits[TEMP_HI:TEMP_LO];  // R18
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
         next_addr_ff <= nxt_next_addr;
         switched_ff <= nxt_switched;
         trig_prev_ff <= trigger_in;
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_rvalid = rvalid_ff;
   assign reg_next_addr = next_addr_ff;
   assign pressure_threshold_bits = thresh_ff;
   assign pressure_offset_bits = offset_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   AST_MODE_APPLY: assert property (take |=> mode_ff == $past(ctrl_ff[MODE_HI:MODE_LO])) // R1
      else $error("Mode not applied at sample");
   AST_WTM_FLAG: assert property (reg_rd && reg_addr == ADDR_FIFO_STATUS |=> // R14
      reg_rdata[7] == ($past(count_ff) >= CNT_W'($past(ctrl_ff[WTM_HI:WTM_LO]))))
      else $error("Watermark flag wrong");
   AST_FULL_EMPTY: assert property (reg_rd && reg_addr == ADDR_FIFO_STATUS |=> // R15 R16
      reg_rdata[6] == ($past(count_ff) == CNT_W'(STORE_DEPTH)) && reg_rdata[5] == ($past(count_ff) == '0))
      else $error("Full or empty flag wrong");
   AST_BYPASS_DIRECT: assert property (take && take_bh == BH_BYPASS |=> // R3
      count_ff == '0 && result_ff == $past(q_data))
      else $error("Bypass did not pass sample or clear store");
   AST_FIFO_STOP: assert property (take && take_bh == BH_FIFO && count_ff == CNT_W'(STORE_DEPTH) |=> // R4
      $stable(wr_ptr_ff) && count_ff == CNT_W'(STORE_DEPTH))
      else $error("Full FIFO kept storing");
   AST_STREAM_DROP: assert property (take && take_bh == BH_STREAM && count_ff == CNT_W'(STORE_DEPTH) |=> // R5
      rd_ptr_ff == PTR_W'($past(rd_ptr_ff) + 1'h1) && count_ff == CNT_W'(STORE_DEPTH))
      else $error("Stream did not drop oldest");
   // Reload lands on the third edge after the pop; only a sample taken at that edge may defer it
   AST_POP_HEAD: assert property (pop_req |=> count_ff == CNT_W'($past(count_ff) - 1'h1) ##3 // R22
      (loaded_ff || count_ff == '0 || !accessible || $past(take)))
      else $error("Pop or reload failed");
   AST_BURST_WRAP: assert property (reg_rd && reg_addr == ADDR_PRESS_H && accessible |=> // R23
      reg_next_addr == ADDR_PRESS_XL)
      else $error("Burst address did not wrap");
   AST_MEAN_HIDDEN: assert property (reg_rd && cur_bh == BH_MEAN && !take |=> $stable(rd_ptr_ff)) // R13
      else $error("Average mode popped an entry");
   AST_MEAN_WINDOW: assert property (take && take_bh == BH_MEAN && last_bh_ff == BH_MEAN && // R11
      count_ff >= window |=> $stable(count_ff))
      else $error("Average window grew");
   AST_DEPTH: assert property (count_ff <= CNT_W'(STORE_DEPTH)) // R21
      else $error("Store over depth");
   AST_TRIG_SWITCH: assert property (trig_prev_ff && !trigger_in |=> switched_ff) // R24
      else $error("Trigger release lost");
   AST_OFFSET_WRITE: assert property (reg_wr && reg_addr == ADDR_OFFSET_L |=> // R20
      pressure_offset_bits == $past(reg_wdata))
      else $error("Offset write lost");

   COV_FIFO_FULL: cover property (take && take_bh == BH_FIFO && count_ff == CNT_W'(STORE_DEPTH));
   COV_STREAM_WRAP: cover property (take && take_bh == BH_STREAM && count_ff == CNT_W'(STORE_DEPTH));
   COV_MEAN_SLIDE: cover property (take && take_bh == BH_MEAN && count_ff >= window);
   COV_TRIG_BYPASS_FIFO: cover property (mode_ff == MODE_BYPASS_TO_FIFO && switched_ff && take);
endmodule

// ===== verif/pressure_sample_source.sv
`timescale 1ns/1ps
module pressure_sample_source (
   input wire logic sys_clk,
   input wire logic sample_ready,
   output logic sample_valid,
   output logic [pressure_fifo_pkg::SAMPLE_W-1:0] sample_data
);
   initial begin
      sample_valid = 1'b0;
      sample_data = 24'h00_0000;
   end
   // Holds the word until taken or 500 cycles pass, then shows its inverse so stale data never passes for fresh
   task automatic send(input logic [23:0] d, output bit ok);
      int n;
      n = 0;
      @(posedge sys_clk);
      sample_valid <= 1'b1;
      sample_data <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (sample_ready !== 1'b1 && n < 500);
      ok = (sample_ready === 1'b1);
      sample_valid <= 1'b0;
      sample_data <= ~d;
   endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import pressure_fifo_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic sample_valid, sample_ready, reg_rvalid;
   logic trigger_in = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [SAMPLE_W-1:0] sample_data;
   logic [TEMP_W-1:0] temperature_sample_bits = 16'h0000;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, reg_next_addr, pressure_offset_bits, rd;
   logic [15:0] pressure_threshold_bits, thr;
   logic [23:0] s [36];
   logic [23:0] v;
   logic [7:0] ra [5] = '{ADDR_FIFO_CTRL, ADDR_THRESH_L, ADDR_THRESH_H, ADDR_OFFSET_L, 8'h3F};
   logic [7:0] re [5] = '{FIFO_CTRL_RESET, THRESH_RESET, THRESH_RESET, OFFSET_L_RESET, READ_IDLE};
   logic [2:0] tc [3] = '{MODE_STREAM_TO_FIFO, MODE_BYPASS_TO_STREAM, MODE_BYPASS_TO_FIFO};
   int pl [3] = '{2, 0, 0};
   int hd [3] = '{0, 4, 2};
   int error_cnt = 0;
   int checked = 0;

   always #25 sys_clk = ~sys_clk;

   pressure_sample_fifo_control i_pressure_sample_fifo_control (.sys_clk(sys_clk), .rst_b(rst_b),
      .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
      .temperature_sample_bits(temperature_sample_bits), .trigger_in(trigger_in), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_next_addr(reg_next_addr),
      .pressure_threshold_bits(pressure_threshold_bits), .pressure_offset_bits(pressure_offset_bits));

   pressure_sample_source i_pressure_sample_source (.sys_clk(sys_clk), .sample_ready(sample_ready),
      .sample_valid(sample_valid), .sample_data(sample_data));

   function automatic logic [7:0] st(int l, int w);
      return {l >= w, l == 32, l == 0, 5'(l)};
   endfunction

   function automatic logic [23:0] mean(int b, int n, int sh);
      logic signed [31:0] acc;
      acc = 0;
      for (int i = b; i < b + n; i++) acc += 32'(signed'(s[i]));
      return 24'(acc >>> sh);
   endfunction

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdr(logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("read answer", 1, reg_rvalid);
      d = reg_rdata;
   endtask

   // Polls status under a bound; the drain rate into the store is not fixed
   task automatic wait_st(int l, int w);
      logic [7:0] d;
      for (int n = 0; n < 100; n++) begin
         rdr(ADDR_FIFO_STATUS, d);
         if (d === st(l, w)) return;
      end
      chk("status", st(l, w), d);
      finish_test();
   endtask

   task automatic push(int n, int b, bit rnd);
      bit ok;
      for (int i = b; i < b + n; i++) begin
         if (rnd) s[i] = 24'($urandom());
         i_pressure_sample_source.send(s[i], ok);
         if (!ok) begin
            chk("sample taken", 1, 0);
            finish_test();
         end
      end
   endtask

   task automatic pop(output logic [23:0] p);
      logic [7:0] b0, b1, b2;
      rdr(ADDR_PRESS_XL, b0);
      rdr(ADDR_PRESS_L, b1);
      rdr(ADDR_PRESS_H, b2);
      p = {b2, b1, b0};
      repeat (6) @(posedge sys_clk);
   endtask

   task automatic clear();
      wr(ADDR_FIFO_CTRL, {MODE_BYPASS, 5'h00});
      push(1, 0, 1);
      repeat (30) @(posedge sys_clk);
   endtask

   initial begin
      repeat (90000) @(posedge sys_clk);
      chk("run length", 0, 1);
      finish_test();
   end

   initial begin
      void'($urandom(19207));
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      foreach (ra[i]) begin
         rdr(ra[i], rd);
         chk("reset value", re[i], rd);
      end
      rdr(ADDR_FIFO_STATUS, rd);
      chk("status reset", st(0, 0), rd);
      $display("Test reset done");
      thr = 16'($urandom());
      temperature_sample_bits <= thr ^ 16'h3C3C;
      wr(ADDR_THRESH_L, thr[7:0]);
      wr(ADDR_THRESH_H, thr[15:8]);
      wr(ADDR_OFFSET_L, thr[7:0] ^ 8'hA5);
      wr(ADDR_FIFO_STATUS, 8'h5A);
      rdr(ADDR_THRESH_H, rd);
      chk("threshold high", thr[15:8], rd);
      chk("threshold port", thr, pressure_threshold_bits);
      chk("offset port", thr[7:0] ^ 8'hA5, pressure_offset_bits);
      rdr(ADDR_TEMP_H, rd);
      chk("temperature high", temperature_sample_bits[15:8], rd);
      rdr(ADDR_FIFO_STATUS, rd);
      chk("status read only", st(0, 0), rd);
      $display("Test registers done");
      clear();
      wr(ADDR_FIFO_CTRL, {MODE_FIFO, 5'h04});
      push(34, 0, 1);
      wait_st(32, 4);
      repeat (30) @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         pop(v);
         chk("fifo entry", s[i], v);
      end
      chk("burst wrap", ADDR_PRESS_XL, reg_next_addr);
      wait_st(29, 4);
      wr(ADDR_FIFO_CTRL, {MODE_FIFO, 5'h1D});
      wait_st(29, 29);
      wr(ADDR_FIFO_CTRL, {MODE_FIFO, 5'h1E});
      wait_st(29, 30);
      $display("Test fifo done");
      clear();
      wait_st(0, 0);
      pop(v);
      chk("bypass result", s[0], v);
      wr(ADDR_FIFO_CTRL, {MODE_STREAM, 5'h00});
      push(34, 0, 1);
      wait_st(32, 0);
      repeat (30) @(posedge sys_clk);
      pop(v);
      chk("stream oldest", s[2], v);
      $display("Test stream done");
      foreach (tc[i]) begin
         clear();
         trigger_in <= 1'b1;
         wr(ADDR_FIFO_CTRL, {tc[i], 5'h00});
         push(2, 0, 1);
         repeat (30) @(posedge sys_clk);
         wait_st(pl[i], 0);
         trigger_in <= 1'b0;
         push(34, 2, 1);
         wait_st(32, 0);
         repeat (30) @(posedge sys_clk);
         pop(v);
         chk("trigger head", s[hd[i]], v);
      end
      $display("Test trigger done");
      clear();
      s[0] = 24'h80_0000;
      s[1] = 24'h7F_FFFF;
      s[2] = 24'hFF_FFFF;
      s[3] = 24'h00_0001;
      wr(ADDR_FIFO_CTRL, {MODE_MEAN, 5'h03});
      push(4, 0, 0);
      wait_st(4, 3);
      repeat (2) begin
         pop(v);
         chk("running average", mean(0, 4, 2), v);
      end
      // One more sample slides the window: oldest leaves the sum, newest joins
      push(1, 4, 1);
      repeat (12) @(posedge sys_clk);
      pop(v);
      chk("sliding average", mean(1, 4, 2), v);
      wait_st(4, 3);
      $display("Test average done");
      finish_test();
   end
endmodule
